// *** scct_core_op_timing.sv ***
// Instruction length and timing decoder of the single-cycle core.
// Assumes code bytes arrive on the core clock from the fetch unit.
`timescale 1ns/10ps
// What this block does
// - Register add, addc, subb: 1 byte, 1 cycle.
// - Indirect accumulator arithmetic: 1 byte, 2 cycles.
// - Direct or immediate arithmetic: 2 bytes, 2 cycles.
// - Logic immediate into direct: 3 bytes, 3 cycles.
// - Single-operand accumulator operations: 1 byte, 1 cycle.
// - Direct to direct move: 3 bytes, 3 cycles.
// - Pointer pair immediate load: 3 bytes, 3 cycles.
// - Code byte reads: 1 byte, 4 cycles.
// - External data moves: 1 byte, 4 cycles.
// - Wait states stretch external moves to 4+n.
// - Push and pop: 2 bytes, 2 cycles.
// - Indirect load of accumulator: 1 byte, 2 cycles.
// - Register exchange: 1 byte, 1 cycle.
// - Nibble exchange: 1 byte, 2 cycles.
// - Carry with direct bit: 2 bytes, 2 cycles.
// - Indirect jump: 1 byte, 3 cycles.
// - Absolute jump and call: 2 bytes, 3 cycles.
// - One counted cycle is one core clock.
// - Interrupt long call takes 3 cycles.
module scct_core_op_timing (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic code_valid,
	input wire logic [scct_pkg::OP_W-1:0] code_byte,
	input wire logic from_irq,
	input wire logic [scct_pkg::WAIT_W-1:0] external_wait_states,
	output logic code_ready,
	output logic instr_start,
	output logic instr_busy,
	output logic instr_done,
	output logic [scct_pkg::LEN_W-1:0] instr_len,
	output logic [scct_pkg::CYC_W-1:0] instr_cycles,
	output scct_pkg::scct_class_t instr_class,
	output logic instr_known,
	output logic external_data_move,
	output scct_pkg::scct_operand_t operands,
	output logic operands_valid
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic {ST_OPCODE, ST_OPERAND} scct_state_t;

	scct_state_t state_reg;
	scct_state_t state_next;
	logic [scct_pkg::LEN_W-1:0] need_reg;
	logic [scct_pkg::LEN_W-1:0] need_next;
	logic ready_reg;
	logic ready_next;
	logic start_reg;
	logic start_next;
	logic [scct_pkg::LEN_W-1:0] len_reg;
	logic [scct_pkg::LEN_W-1:0] len_next;
	logic [scct_pkg::CYC_W-1:0] cycles_reg;
	logic [scct_pkg::CYC_W-1:0] cycles_next;
	scct_pkg::scct_class_t class_reg;
	scct_pkg::scct_class_t class_next;
	logic known_reg;
	logic known_next;
	logic xdata_reg;
	logic xdata_next;
	scct_pkg::scct_operand_t opnd_reg;
	scct_pkg::scct_operand_t opnd_next;
	logic opv_reg;
	logic opv_next;
	scct_pkg::scct_decode_t dec;
	logic take_op;
	logic take_opnd;
	logic [scct_pkg::CYC_W-1:0] total_cycles;
	logic [scct_pkg::CYC_W-1:0] run_clocks;
	logic timer_idle_next;
	scct_pkg::scct_class_t take_cls;

	// ------------------------------------------------------------
	// Opcode classification and cycle timer
	// ------------------------------------------------------------
	scct_op_classify u_classify (
		.op_byte(code_byte),
		.from_irq(from_irq),
		.dec(dec)
	);

	scct_cycle_timer #(
		.CW(scct_pkg::CYC_W)
	) u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(take_op),
		.load_count(run_clocks),
		.busy(instr_busy),
		.last(instr_done),
		.idle_next(timer_idle_next)
	);

	// ------------------------------------------------------------
	// Byte stream and instruction timing
	// ------------------------------------------------------------
	always_comb begin
		take_op = code_valid && ready_reg && (state_reg == ST_OPCODE);
		take_opnd = code_valid && ready_reg && (state_reg == ST_OPERAND);
		take_cls = take_op ? dec.cls : scct_pkg::CL_IDLE;
		total_cycles = dec.cycles;
		if (dec.xdata) begin
			total_cycles = dec.cycles + scct_pkg::CYC_W'(external_wait_states);
		end
		run_clocks = scct_pkg::CYC_W'(total_cycles * scct_pkg::CLKS_PER_CYCLE);
		state_next = state_reg;
		need_next = need_reg;
		start_next = take_op;
		len_next = len_reg;
		cycles_next = cycles_reg;
		class_next = class_reg;
		known_next = known_reg;
		xdata_next = xdata_reg;
		opnd_next = opnd_reg;
		opv_next = 1'b0;
		if (take_op) begin
			len_next = dec.len;
			cycles_next = total_cycles;
			class_next = dec.cls;
			known_next = dec.known;
			xdata_next = dec.xdata;
			opnd_next = '0;
			if (dec.len != scct_pkg::LEN_ONE) begin
				state_next = ST_OPERAND;
				need_next = dec.len - scct_pkg::LEN_ONE;
			end
		end
		if (take_opnd) begin
			if (need_reg == len_reg - scct_pkg::LEN_ONE) begin
				opnd_next.first = code_byte;
			end else begin
				opnd_next.second = code_byte;
			end
			need_next = need_reg - scct_pkg::LEN_ONE;
			if (need_reg == scct_pkg::LEN_ONE) begin
				state_next = ST_OPCODE;
				opv_next = 1'b1;
			end
		end
		ready_next = (state_next == ST_OPERAND) || timer_idle_next;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_OPCODE;
			need_reg <= scct_pkg::LEN_NONE;
			ready_reg <= 1'b1;
			start_reg <= 1'b0;
			len_reg <= scct_pkg::LEN_NONE;
			cycles_reg <= scct_pkg::CYC_NONE;
			class_reg <= scct_pkg::CL_IDLE;
			known_reg <= 1'b0;
			xdata_reg <= 1'b0;
			opnd_reg <= '0;
			opv_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			need_reg <= need_next;
			ready_reg <= ready_next;
			start_reg <= start_next;
			len_reg <= len_next;
			cycles_reg <= cycles_next;
			class_reg <= class_next;
			known_reg <= known_next;
			xdata_reg <= xdata_next;
			opnd_reg <= opnd_next;
			opv_reg <= opv_next;
		end
	end

	assign code_ready = ready_reg;
	assign instr_start = start_reg;
	assign instr_len = len_reg;
	assign instr_cycles = cycles_reg;
	assign instr_class = class_reg;
	assign instr_known = known_reg;
	assign external_data_move = xdata_reg;
	assign operands = opnd_reg;
	assign operands_valid = opv_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [scct_pkg::CYC_W-1:0] seen_reg;
	logic [scct_pkg::CYC_W-1:0] seen_next;

	always_comb begin
		seen_next = start_reg ? scct_pkg::CYC_ONE : seen_reg + scct_pkg::CYC_ONE;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			seen_reg <= scct_pkg::CYC_NONE;
		end else begin
			seen_reg <= seen_next;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_run_one;
		instr_busy && instr_done;
	endsequence
	sequence s_run_two;
		instr_busy && !instr_done ##1 instr_done;
	endsequence
	sequence s_run_three;
		(instr_busy && !instr_done) [*2] ##1 instr_done;
	endsequence
	sequence s_run_four;
		(instr_busy && !instr_done) [*3] ##1 instr_done;
	endsequence
	sequence s_run_seven;
		(instr_busy && !instr_done) [*6] ##1 instr_done;
	endsequence
	sequence s_run_eleven;
		(instr_busy && !instr_done) [*8] ##1 (instr_busy && !instr_done) [*2] ##1 instr_done;
	endsequence

	arith_reg_time_a: assert property (
		take_cls == scct_pkg::CL_ARITH_REG |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_one)
		else $error("Register arithmetic timing wrong.");
	arith_ind_time_a: assert property (
		take_cls == scct_pkg::CL_ARITH_IND |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_two)
		else $error("Indirect arithmetic timing wrong.");
	arith_dir_time_a: assert property (
		take_cls == scct_pkg::CL_ARITH_DIR |=>
		instr_len == scct_pkg::LEN_TWO ##0 s_run_two)
		else $error("Direct arithmetic timing wrong.");
	logic_imm_time_a: assert property (
		take_cls == scct_pkg::CL_LOGIC_DIR_IMM |=>
		instr_len == scct_pkg::LEN_THREE ##0 s_run_three)
		else $error("Logic immediate timing wrong.");
	acc_unary_time_a: assert property (
		take_cls == scct_pkg::CL_ACC_UNARY |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_one)
		else $error("Accumulator operation timing wrong.");
	move_dir_time_a: assert property (
		take_cls == scct_pkg::CL_MOVE_DIR_DIR |=>
		instr_len == scct_pkg::LEN_THREE ##0 s_run_three)
		else $error("Direct move timing wrong.");
	pointer_load_a: assert property (
		take_cls == scct_pkg::CL_POINTER_LOAD |=>
		instr_len == scct_pkg::LEN_THREE ##0 s_run_three)
		else $error("Pointer pair load timing wrong.");
	code_read_time_a: assert property (
		take_cls == scct_pkg::CL_CODE_READ |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_four)
		else $error("Code byte read timing wrong.");
	xdata_nowait_a: assert property (
		take_cls == scct_pkg::CL_EXT_DATA && external_wait_states == '0 |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_four)
		else $error("External move without waits wrong.");
	xdata_wait_a: assert property (
		take_cls == scct_pkg::CL_EXT_DATA |=>
		external_data_move && instr_cycles ==
		scct_pkg::CYC_XDATA_BASE + scct_pkg::CYC_W'($past(external_wait_states)))
		else $error("External move wait count wrong.");
	xdata_busy_end_a: assert property (
		take_cls == scct_pkg::CL_EXT_DATA && external_wait_states == 3'h7 |=>
		s_run_eleven)
		else $error("External move with seven waits wrong.");
	xdata_mid_wait_a: assert property (
		take_cls == scct_pkg::CL_EXT_DATA && external_wait_states == 3'h3 |=>
		s_run_seven)
		else $error("External move with three waits wrong.");
	stack_time_a: assert property (
		take_cls == scct_pkg::CL_STACK |=>
		instr_len == scct_pkg::LEN_TWO ##0 s_run_two)
		else $error("Push or pop timing wrong.");
	load_ind_time_a: assert property (
		take_cls == scct_pkg::CL_LOAD_IND |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_two)
		else $error("Indirect load timing wrong.");
	xch_reg_time_a: assert property (
		take_cls == scct_pkg::CL_XCH_REG |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_one)
		else $error("Register exchange timing wrong.");
	nibble_time_a: assert property (
		take_cls == scct_pkg::CL_NIBBLE_XCHG |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_two)
		else $error("Nibble exchange timing wrong.");
	bool_carry_time_a: assert property (
		take_cls == scct_pkg::CL_BOOL_CARRY |=>
		instr_len == scct_pkg::LEN_TWO ##0 s_run_two)
		else $error("Carry bit operation timing wrong.");
	jump_ind_time_a: assert property (
		take_cls == scct_pkg::CL_JUMP_IND |=>
		instr_len == scct_pkg::LEN_ONE ##0 s_run_three)
		else $error("Indirect jump timing wrong.");
	abs_branch_time_a: assert property (
		take_cls == scct_pkg::CL_ABS_BRANCH |=>
		instr_len == scct_pkg::LEN_TWO ##0 s_run_three)
		else $error("Absolute branch timing wrong.");
	run_length_a: assert property (
		instr_done |-> seen_next == instr_cycles)
		else $error("Busy span differs from cycle count.");
	irq_call_time_a: assert property (
		take_cls == scct_pkg::CL_LONG_CALL && from_irq |=>
		instr_cycles == scct_pkg::CYC_IRQ_CALL ##0 s_run_three)
		else $error("Interrupt long call timing wrong.");
	plain_call_time_a: assert property (
		take_cls == scct_pkg::CL_LONG_CALL && !from_irq |=>
		instr_cycles == scct_pkg::CYC_FOUR ##0 s_run_four)
		else $error("Plain long call timing wrong.");
	operand_count_a: assert property (
		take_op && dec.len == scct_pkg::LEN_THREE ##1 take_opnd [*2] |=>
		operands_valid)
		else $error("Operand bytes not collected.");
	operand_ready_a: assert property (
		take_op && dec.len != scct_pkg::LEN_ONE |=>
		code_ready && !operands_valid)
		else $error("Operand byte refused after opcode.");
	take_refused_a: assert property (
		state_reg == ST_OPCODE && instr_busy && !instr_done |->
		!code_ready)
		else $error("Opcode accepted before the last busy cycle.");
	start_pulse_a: assert property (
		take_op |=>
		instr_start && instr_busy)
		else $error("Start pulse missing after opcode.");
	done_ends_busy_a: assert property (
		instr_done && !take_op |=>
		!instr_busy)
		else $error("Busy outlasts the last cycle.");
	xdata_flag_a: assert property (
		take_op && !dec.xdata |=>
		!external_data_move)
		else $error("External move flag set for another class.");
	start_counts_a: assert property (
		instr_start |->
		instr_len != scct_pkg::LEN_NONE && instr_cycles != scct_pkg::CYC_NONE)
		else $error("Instruction started with no length or cycles.");
	timing_hold_a: assert property (
		!take_op |=>
		$stable(instr_cycles) && $stable(instr_len))
		else $error("Length or cycle count changed without an opcode.");
endmodule // scct_core_op_timing

// *** scct_pkg.sv ***
// Shared constants and types for the instruction length and timing decoder.
// Assumes one core clock; every consumer names items as scct_pkg::name.
package scct_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int OP_W = 8;
	localparam int LEN_W = 2;
	localparam int CYC_W = 4;
	localparam int WAIT_W = 3;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CORE_CYCLE_PS = 4000;
	localparam int CLKS_PER_CYCLE = (CORE_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [LEN_W-1:0] LEN_NONE = 2'h0;
	localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
	localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
	localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
	localparam logic [CYC_W-1:0] CYC_NONE = 4'h0;
	localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
	localparam logic [CYC_W-1:0] CYC_TWO = 4'h2;
	localparam logic [CYC_W-1:0] CYC_THREE = 4'h3;
	localparam logic [CYC_W-1:0] CYC_FOUR = 4'h4;
	localparam logic [CYC_W-1:0] CYC_NINE = 4'h9;
	localparam logic [CYC_W-1:0] CYC_XDATA_BASE = 4'h4;
	localparam logic [CYC_W-1:0] CYC_IRQ_CALL = 4'h3;
	localparam logic [OP_W-1:0] OP_RESET = 8'h00;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		CL_IDLE, CL_ARITH_REG, CL_ARITH_IND, CL_ARITH_DIR, CL_LOGIC_DIR_IMM,
		CL_ACC_UNARY, CL_MOVE_DIR_DIR, CL_POINTER_LOAD, CL_CODE_READ, CL_EXT_DATA,
		CL_STACK, CL_LOAD_IND, CL_XCH_REG, CL_NIBBLE_XCHG, CL_BOOL_CARRY,
		CL_JUMP_IND, CL_ABS_BRANCH, CL_LONG_CALL, CL_LONG_JUMP, CL_MISC, CL_UNLISTED
	} scct_class_t;
	typedef struct packed {
		scct_class_t cls;
		logic [LEN_W-1:0] len;
		logic [CYC_W-1:0] cycles;
		logic xdata;
		logic known;
	} scct_decode_t;
	typedef struct packed {
		logic [OP_W-1:0] first;
		logic [OP_W-1:0] second;
	} scct_operand_t;
endpackage

// *** scct_op_classify.sv ***
// Opcode classifier: byte count, base cycle count and class of one opcode.
// Assumes a purely combinational use inside the decoder.
`timescale 1ns/10ps
module scct_op_classify (
	input wire logic [scct_pkg::OP_W-1:0] op_byte,
	input wire logic from_irq,
	output scct_pkg::scct_decode_t dec
);
	function automatic scct_pkg::scct_decode_t mk(scct_pkg::scct_class_t c,
		logic [scct_pkg::LEN_W-1:0] l, logic [scct_pkg::CYC_W-1:0] n, logic x);
		mk = '{cls: c, len: l, cycles: n, xdata: x, known: 1'b1};
	endfunction

	always_comb begin
		dec = '{cls: scct_pkg::CL_UNLISTED, len: scct_pkg::LEN_ONE,
			cycles: scct_pkg::CYC_ONE, xdata: 1'b0, known: 1'b0};
		casez (op_byte)
			8'b00101???, 8'b00111???, 8'b10011???: begin
				dec = mk(scct_pkg::CL_ARITH_REG, scct_pkg::LEN_ONE, scct_pkg::CYC_ONE, 1'b0);
			end
			8'b0010011?, 8'b0011011?, 8'b1001011?: begin
				dec = mk(scct_pkg::CL_ARITH_IND, scct_pkg::LEN_ONE, scct_pkg::CYC_TWO, 1'b0);
			end
			8'b0010010?, 8'b0011010?, 8'b1001010?: begin
				dec = mk(scct_pkg::CL_ARITH_DIR, scct_pkg::LEN_TWO, scct_pkg::CYC_TWO, 1'b0);
			end
			8'h43, 8'h53, 8'h63: begin
				dec = mk(scct_pkg::CL_LOGIC_DIR_IMM, scct_pkg::LEN_THREE, scct_pkg::CYC_THREE, 1'b0);
			end
			8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13: begin
				dec = mk(scct_pkg::CL_ACC_UNARY, scct_pkg::LEN_ONE, scct_pkg::CYC_ONE, 1'b0);
			end
			8'h85: begin
				dec = mk(scct_pkg::CL_MOVE_DIR_DIR, scct_pkg::LEN_THREE, scct_pkg::CYC_THREE, 1'b0);
			end
			8'h90: begin
				dec = mk(scct_pkg::CL_POINTER_LOAD, scct_pkg::LEN_THREE, scct_pkg::CYC_THREE, 1'b0);
			end
			8'h83, 8'h93: begin
				dec = mk(scct_pkg::CL_CODE_READ, scct_pkg::LEN_ONE, scct_pkg::CYC_FOUR, 1'b0);
			end
			8'hE0, 8'hF0, 8'b1110001?, 8'b1111001?: begin
				dec = mk(scct_pkg::CL_EXT_DATA, scct_pkg::LEN_ONE, scct_pkg::CYC_XDATA_BASE, 1'b1);
			end
			8'hC0, 8'hD0: begin
				dec = mk(scct_pkg::CL_STACK, scct_pkg::LEN_TWO, scct_pkg::CYC_TWO, 1'b0);
			end
			8'b1110011?: begin
				dec = mk(scct_pkg::CL_LOAD_IND, scct_pkg::LEN_ONE, scct_pkg::CYC_TWO, 1'b0);
			end
			8'b11001???: begin
				dec = mk(scct_pkg::CL_XCH_REG, scct_pkg::LEN_ONE, scct_pkg::CYC_ONE, 1'b0);
			end
			8'b1101011?: begin
				dec = mk(scct_pkg::CL_NIBBLE_XCHG, scct_pkg::LEN_ONE, scct_pkg::CYC_TWO, 1'b0);
			end
			8'h72, 8'h82, 8'hA0, 8'hB0: begin
				dec = mk(scct_pkg::CL_BOOL_CARRY, scct_pkg::LEN_TWO, scct_pkg::CYC_TWO, 1'b0);
			end
			8'h73: begin
				dec = mk(scct_pkg::CL_JUMP_IND, scct_pkg::LEN_ONE, scct_pkg::CYC_THREE, 1'b0);
			end
			8'b???00001, 8'b???10001: begin
				dec = mk(scct_pkg::CL_ABS_BRANCH, scct_pkg::LEN_TWO, scct_pkg::CYC_THREE, 1'b0);
			end
			8'h12: begin
				dec = mk(scct_pkg::CL_LONG_CALL, scct_pkg::LEN_THREE,
					from_irq ? scct_pkg::CYC_IRQ_CALL : scct_pkg::CYC_FOUR, 1'b0);
			end
			8'h02: begin
				dec = mk(scct_pkg::CL_LONG_JUMP, scct_pkg::LEN_THREE, scct_pkg::CYC_FOUR, 1'b0);
			end
			8'h00: begin
				dec = mk(scct_pkg::CL_MISC, scct_pkg::LEN_ONE, scct_pkg::CYC_ONE, 1'b0);
			end
			8'hA3: begin
				dec = mk(scct_pkg::CL_MISC, scct_pkg::LEN_ONE, scct_pkg::CYC_THREE, 1'b0);
			end
			8'hA4, 8'h22, 8'h32: begin
				dec = mk(scct_pkg::CL_MISC, scct_pkg::LEN_ONE, scct_pkg::CYC_FOUR, 1'b0);
			end
			8'h84: begin
				dec = mk(scct_pkg::CL_MISC, scct_pkg::LEN_ONE, scct_pkg::CYC_NINE, 1'b0);
			end
			default: begin
				dec.known = 1'b0;
			end
		endcase
	end
endmodule // scct_op_classify

// *** scct_cycle_timer.sv ***
// Down counter that holds an instruction busy for its cycle count.
// Assumes load is only raised when idle_next was high the cycle before.
`timescale 1ns/10ps
module scct_cycle_timer #(
	parameter int CW = scct_pkg::CYC_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [CW-1:0] load_count,
	output logic busy,
	output logic last,
	output logic idle_next
);
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic busy_next;
	logic last_next;

	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = load_count;
		end else if (count_reg != '0) begin
			count_next = count_reg - CW'(1);
		end
		busy_next = (count_next != '0);
		last_next = (count_next == CW'(1));
		idle_next = (count_next <= CW'(1));
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			busy <= 1'b0;
			last <= 1'b0;
		end else begin
			count_reg <= count_next;
			busy <= busy_next;
			last <= last_next;
		end
	end
endmodule // scct_cycle_timer

// *** scct_core_op_timing_tb_top.sv ***
// Self-checking bench for the instruction length and timing decoder.
// Assumes the decoder package is compiled first and one core clock of 4 ns.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module scct_core_op_timing_tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic ref_clk;
	logic rst;
	logic code_valid;
	logic [7:0] code_byte;
	logic from_irq;
	logic [2:0] external_wait_states;
	logic code_ready;
	logic instr_start;
	logic instr_busy;
	logic instr_done;
	logic [1:0] instr_len;
	logic [3:0] instr_cycles;
	scct_pkg::scct_class_t instr_class;
	logic instr_known;
	logic external_data_move;
	scct_pkg::scct_operand_t operands;
	logic operands_valid;
	int n_fail = 0;
	int checks = 0;
	int seed;
	int idx;
	logic [7:0] pool [$] = {8'h28, 8'h2F, 8'h38, 8'h98, 8'h9F, 8'h26, 8'h27, 8'h36, 8'h97,
		8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h43, 8'h53, 8'h63, 8'hE4, 8'hF4, 8'hC4,
		8'h23, 8'h33, 8'h03, 8'h13, 8'h85, 8'h90, 8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0,
		8'hF2, 8'hF3, 8'hC0, 8'hD0, 8'hE6, 8'hE7, 8'hC8, 8'hCF, 8'hD6, 8'hD7, 8'h82, 8'hB0,
		8'h72, 8'hA0, 8'h73, 8'h01, 8'h11, 8'hE1, 8'hF1, 8'h12, 8'h56,
		8'h02, 8'h00, 8'hA3, 8'hA4, 8'h84, 8'h22, 8'h32};
	// ------------------------------------------------------------
	// Design and clock
	// ------------------------------------------------------------
	scct_core_op_timing dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.code_valid(code_valid),
		.code_byte(code_byte),
		.from_irq(from_irq),
		.external_wait_states(external_wait_states),
		.code_ready(code_ready),
		.instr_start(instr_start),
		.instr_busy(instr_busy),
		.instr_done(instr_done),
		.instr_len(instr_len),
		.instr_cycles(instr_cycles),
		.instr_class(instr_class),
		.instr_known(instr_known),
		.external_data_move(external_data_move),
		.operands(operands),
		.operands_valid(operands_valid)
	);
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;
	// ------------------------------------------------------------
	// Expected decode of one opcode
	// ------------------------------------------------------------
	function automatic scct_pkg::scct_decode_t expect_op(input logic [7:0] op, input logic irq,
		input logic [2:0] ws);
		scct_pkg::scct_decode_t d;
		d = '{cls: scct_pkg::CL_UNLISTED, len: 2'h1, cycles: 4'h1, xdata: 1'b0, known: 1'b1};
		casez (op)
			8'b0010_1???, 8'b0011_1???, 8'b1001_1???: d.cls = scct_pkg::CL_ARITH_REG;
			8'b0010_011?, 8'b0011_011?, 8'b1001_011?: d.cls = scct_pkg::CL_ARITH_IND;
			8'b0010_010?, 8'b0011_010?, 8'b1001_010?: d.cls = scct_pkg::CL_ARITH_DIR;
			8'h43, 8'h53, 8'h63: d.cls = scct_pkg::CL_LOGIC_DIR_IMM;
			8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13: d.cls = scct_pkg::CL_ACC_UNARY;
			8'h85: d.cls = scct_pkg::CL_MOVE_DIR_DIR;
			8'h90: d.cls = scct_pkg::CL_POINTER_LOAD;
			8'h83, 8'h93: d.cls = scct_pkg::CL_CODE_READ;
			8'b111?_0000, 8'b111?_001?: d.cls = scct_pkg::CL_EXT_DATA;
			8'hC0, 8'hD0: d.cls = scct_pkg::CL_STACK;
			8'b1110_011?: d.cls = scct_pkg::CL_LOAD_IND;
			8'b1100_1???: d.cls = scct_pkg::CL_XCH_REG;
			8'b1101_011?: d.cls = scct_pkg::CL_NIBBLE_XCHG;
			8'h82, 8'hB0, 8'h72, 8'hA0: d.cls = scct_pkg::CL_BOOL_CARRY;
			8'h73: d.cls = scct_pkg::CL_JUMP_IND;
			8'b????_0001: d.cls = scct_pkg::CL_ABS_BRANCH;
			8'h12: d.cls = scct_pkg::CL_LONG_CALL;
			8'h02: d.cls = scct_pkg::CL_LONG_JUMP;
			8'h00, 8'hA3, 8'hA4, 8'h84, 8'h22, 8'h32: d.cls = scct_pkg::CL_MISC;
			default: d.known = 1'b0;
		endcase
		case (d.cls)
			scct_pkg::CL_ARITH_IND, scct_pkg::CL_LOAD_IND, scct_pkg::CL_NIBBLE_XCHG: d.cycles = 4'h2;
			scct_pkg::CL_ARITH_DIR, scct_pkg::CL_STACK, scct_pkg::CL_BOOL_CARRY: begin
				d.len = 2'h2;
				d.cycles = 4'h2;
			end
			scct_pkg::CL_LOGIC_DIR_IMM, scct_pkg::CL_MOVE_DIR_DIR, scct_pkg::CL_POINTER_LOAD: begin
				d.len = 2'h3;
				d.cycles = 4'h3;
			end
			scct_pkg::CL_CODE_READ: d.cycles = 4'h4;
			scct_pkg::CL_EXT_DATA: begin
				d.cycles = 4'h4 + {1'b0, ws};
				d.xdata = 1'b1;
			end
			scct_pkg::CL_JUMP_IND: d.cycles = 4'h3;
			scct_pkg::CL_ABS_BRANCH: begin
				d.len = 2'h2;
				d.cycles = 4'h3;
			end
			scct_pkg::CL_LONG_CALL: begin
				d.len = 2'h3;
				d.cycles = irq ? 4'h3 : 4'h4;
			end
			scct_pkg::CL_LONG_JUMP: begin
				d.len = 2'h3;
				d.cycles = 4'h4;
			end
			scct_pkg::CL_MISC: d.cycles = (op == 8'h84) ? 4'h9 : (op == 8'hA3) ? 4'h3 :
				(op == 8'h00) ? 4'h1 : 4'h4;
			default: d.cycles = 4'h1;
		endcase
		return d;
	endfunction
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk_idle(input scct_pkg::scct_class_t cls);
		begin
			`CHK("code_ready", 1'b1, code_ready)
			`CHK("instr_busy", 1'b0, instr_busy)
			`CHK("instr_class", cls, instr_class)
		end
	endtask
	task automatic run_op(input logic [7:0] op, input logic irq, input logic [2:0] ws);
		scct_pkg::scct_decode_t e;
		logic [7:0] b1;
		logic [7:0] b2;
		int n;
		begin
			e = expect_op(op, irq, ws);
			b1 = 8'($random(seed));
			b2 = 8'($random(seed));
			n = int'(e.cycles);
			`CHK("code_ready", 1'b1, code_ready)
			code_valid = 1'b1;
			code_byte = op;
			from_irq = irq;
			external_wait_states = ws;
			@(negedge ref_clk);
			`CHK("instr_len", e.len, instr_len)
			`CHK("instr_cycles", e.cycles, instr_cycles)
			`CHK("instr_class", e.cls, instr_class)
			`CHK("instr_known", e.known, instr_known)
			`CHK("external_data_move", e.xdata, external_data_move)
			for (int k = 1; k <= n; k++) begin
				if (k > 1)
					@(negedge ref_clk);
				`CHK("instr_busy", 1'b1, instr_busy)
				`CHK("instr_start", 1'(k == 1), instr_start)
				`CHK("instr_done", 1'(k == n), instr_done)
				`CHK("operands_valid", 1'(k == e.len && e.len > 1), operands_valid)
				if (k == e.len && e.len > 1) begin
					`CHK("operands_first", b1, operands.first)
				end
				if (k == 3 && e.len == 3) begin
					`CHK("operands_second", b2, operands.second)
				end
				if (k < e.len) begin
					`CHK("code_ready", 1'b1, code_ready)
				end else if (k < n) begin
					`CHK("code_ready", 1'b0, code_ready)
				end
				if (k < n) begin
					from_irq = 1'b0;
					if (k < e.len)
						code_byte = (k == 1) ? b1 : b2;
					else
						code_valid = 1'b0;
				end
			end
		end
	endtask
	task close_out;
		begin
			if (n_fail == 0 && checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		#200000;
		n_fail++;
		close_out;
	end
	initial begin
		seed = 32'hdb04;
		rst = 1'b1;
		code_valid = 1'b0;
		code_byte = 8'h00;
		from_irq = 1'b0;
		external_wait_states = 3'h0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk_idle(scct_pkg::CL_IDLE);
		rst = 1'b0;
		@(negedge ref_clk);
		foreach (pool[i])
			run_op(pool[i], 1'b0, 3'h0);
		for (int w = 0; w < 8; w++)
			run_op(pool[29 + (w % 6)], 1'b0, 3'(w));
		run_op(8'h12, 1'b1, 3'h0);
		run_op(8'h12, 1'b0, 3'h0);
		repeat (300) begin
			idx = int'($unsigned($random(seed)) % pool.size());
			run_op(pool[idx], (pool[idx] == 8'h12) ? 1'($random(seed)) : 1'b0, 3'($random(seed)));
		end
		code_valid = 1'b1;
		code_byte = 8'hF3;
		external_wait_states = 3'h7;
		@(negedge ref_clk);
		code_valid = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst = 1'b1;
		@(negedge ref_clk);
		chk_idle(scct_pkg::CL_IDLE);
		`CHK("instr_done", 1'b0, instr_done)
		rst = 1'b0;
		@(negedge ref_clk);
		run_op(8'h85, 1'b0, 3'h0);
		code_valid = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk_idle(scct_pkg::CL_MOVE_DIR_DIR);
		close_out;
	end
endmodule // scct_core_op_timing_tb_top
